// File: core/tgs_pkg.sv
package tgs_pkg;
   localparam int          TGS_TABLE_DEPTH = 148;
   localparam int          TGS_ENTRY_W     = 9;
   localparam int          TGS_CLK_PER_TS  = 2;
   localparam int          TGS_DWELL_UNIT  = 33;
   localparam int          TGS_SUBSTEPS    = 8;
   localparam logic [5:0]  TGS_WHOLE_MAX   = 6'h24;
   localparam logic [8:0]  TGS_GAIN_MAX    = 9'h127;
   localparam logic [3:0]  TGS_FINE_DELTA  = 4'h1;
   localparam logic [3:0]  TGS_COARSE_DLT  = 4'h8;
   // register offsets
   localparam logic [7:0]  TGS_OFS_BANK    = 8'h00;
   localparam logic [7:0]  TGS_OFS_TBL_LO  = 8'h01;
   localparam logic [7:0]  TGS_OFS_TBL_HI  = 8'h94;
   localparam logic [7:0]  TGS_OFS_FIRST   = 8'h95;
   localparam logic [7:0]  TGS_OFS_LAST    = 8'h96;
   localparam logic [7:0]  TGS_OFS_INIT    = 8'h97;
   localparam logic [7:0]  TGS_OFS_DWELL   = 8'h98;
   localparam logic [7:0]  TGS_OFS_MODE    = 8'h99;
   localparam logic [7:0]  TGS_OFS_WHOLE   = 8'h9a;
   localparam logic [7:0]  TGS_OFS_RATE    = 8'h9b;
   // field positions
   localparam int          TGS_BIT_BANK    = 2;
   localparam int          TGS_BIT_FINE    = 7;
   localparam int          TGS_BIT_FREE    = 5;
   localparam int          TGS_BIT_LINEAR  = 4;
   localparam int          TGS_BIT_FIXED   = 3;
   localparam int          TGS_BIT_DECR    = 8;
   // reset values
   localparam logic [7:0]  TGS_RST_BYTE    = 8'h00;
   localparam logic [5:0]  TGS_RST_MODE    = 6'h00;

   typedef enum logic [1:0] {
      TGS_IDLE   = 2'b00,
      TGS_RAMP   = 2'b01,
      TGS_DWELL  = 2'b10,
      TGS_RETURN = 2'b11
   } tgs_state_e;
endpackage : tgs_pkg

// File: core/tgs_time_gain_sequencer.sv
// Functional notes
// - last-entry pointer selects final entry, 1..148
// - initial gain code is -5 dB plus value
// - final gain follows index span, decrements, fine
// - dwell lasts 33 times dwell count periods
// - after dwell return 1 dB per period
// - fine ramp: 0.125 dB every rate periods
// - coarse ramp: 1 dB every 8*rate periods
// - free-run bit repeats profile without pin
// - ramp select bit picks table or uniform
// - fixed select gives whole plus eighth gain
// - whole gain code above 0x24 clamps
// - eighth gain adds 0.125 dB per count
// - gain changes only at sampling instants
// - 148 nine-bit entries writable in table bank
// - fine mode splits 1 dB into eight steps
// - start pin loads initial gain, walks immediately
// - walk ends at last entry or limit
// - hardware trigger mode idles after return
// - start pin sampled at sampling clock edge
// - free-run restarts after return until cleared
// - sample period is two input clocks
// - bank bit at register 0 routes addresses
// - uniform mode only rises, span sets height
module tgs_time_gain_sequencer #(
   parameter int DWELL_UNIT = tgs_pkg::TGS_DWELL_UNIT
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        regWrEn,
   input  wire logic [7:0]  regAddr,
   input  wire logic [15:0] regWrData,
   output logic      [15:0] regRdData,
   input  wire logic        startPin,
   output logic      [8:0]  gainCode,
   output logic             engineBusy
);
   logic                  tick;
   logic                  startMeta;
   logic                  startSync;
   logic                  bankSel;
   logic [7:0]            firstIdx;
   logic [7:0]            lastIdx;
   logic [7:0]            initReg;
   logic [7:0]            dwellReg;
   logic [5:0]            modeReg;
   logic [5:0]            wholeReg;
   logic [7:0]            rateReg;
   logic [8:0]            tbl [1:tgs_pkg::TGS_TABLE_DEPTH];
   tgs_pkg::tgs_state_e   state;
   logic [7:0]            idx;
   logic [7:0]            remain;
   logic [7:0]            subCnt;
   logic [2:0]            subIdx;
   logic [13:0]           dwellCnt;
   logic [8:0]            entry;
   logic [7:0]            unitLen;
   logic [3:0]            delta;
   logic                  goDown;
   logic                  fineSel;
   logic                  freeRun;
   logic                  linearSel;
   logic                  fixedSel;
   logic [8:0]            initCode;
   logic [8:0]            fixedCode;
   logic [5:0]            wholeClamped;
   logic [9:0]            stepUp;
   logic                  outOfRange;
   logic [8:0]            next_gain;
   logic                  lastSub;
   logic [15:0]           next_rdData;

   function automatic logic inTable(input logic [7:0] a);
      inTable = (a >= tgs_pkg::TGS_OFS_TBL_LO) && (a <= tgs_pkg::TGS_OFS_TBL_HI);
   endfunction : inTable

   assign fineSel   = initReg[tgs_pkg::TGS_BIT_FINE];
   assign freeRun   = modeReg[tgs_pkg::TGS_BIT_FREE];
   assign linearSel = modeReg[tgs_pkg::TGS_BIT_LINEAR];
   assign fixedSel  = modeReg[tgs_pkg::TGS_BIT_FIXED];
   assign initCode  = {initReg[5:0], 3'h0};
   assign engineBusy = (state != tgs_pkg::TGS_IDLE);

   // gain held in eighths of a dB above -5 dB
   assign wholeClamped = (wholeReg > tgs_pkg::TGS_WHOLE_MAX) ?
                         tgs_pkg::TGS_WHOLE_MAX : wholeReg;
   assign fixedCode = {wholeClamped, modeReg[2:0]};

   // sampling-clock phase: engine advances every second input clock
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= ~tick;
      end
   end

   // the pin comes from another clock domain
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         startMeta <= 1'b0;
         startSync <= 1'b0;
      end else begin
         startMeta <= startPin;
         startSync <= startMeta;
      end
   end

   // configuration registers; address 0 is reachable in either bank
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bankSel  <= 1'b0;
         firstIdx <= tgs_pkg::TGS_RST_BYTE;
         lastIdx  <= tgs_pkg::TGS_RST_BYTE;
         initReg  <= tgs_pkg::TGS_RST_BYTE;
         dwellReg <= tgs_pkg::TGS_RST_BYTE;
         modeReg  <= tgs_pkg::TGS_RST_MODE;
         wholeReg <= tgs_pkg::TGS_RST_MODE;
         rateReg  <= tgs_pkg::TGS_RST_BYTE;
      end else if (regWrEn) begin
         if (regAddr == tgs_pkg::TGS_OFS_BANK) begin
            bankSel <= regWrData[tgs_pkg::TGS_BIT_BANK];
         end else if (bankSel) begin
            case (regAddr)
               tgs_pkg::TGS_OFS_FIRST: firstIdx <= regWrData[7:0];
               tgs_pkg::TGS_OFS_LAST:  lastIdx  <= regWrData[7:0];
               tgs_pkg::TGS_OFS_INIT:  initReg  <= {regWrData[7], 1'b0, regWrData[5:0]};
               tgs_pkg::TGS_OFS_DWELL: dwellReg <= regWrData[7:0];
               tgs_pkg::TGS_OFS_MODE:  modeReg  <= regWrData[5:0];
               tgs_pkg::TGS_OFS_WHOLE: wholeReg <= regWrData[5:0];
               tgs_pkg::TGS_OFS_RATE:  rateReg  <= regWrData[7:0];
               default: ;
            endcase
         end
      end
   end

   // profile memory, no reset: contents are undefined until loaded
   always_ff @(posedge clk) begin
      if (regWrEn && bankSel && inTable(regAddr)) begin
         tbl[regAddr] <= regWrData[8:0];
      end
   end

   always_comb begin
      next_rdData = 16'h0000;
      if (regAddr == tgs_pkg::TGS_OFS_BANK) begin
         next_rdData[tgs_pkg::TGS_BIT_BANK] = bankSel;
      end else if (bankSel && inTable(regAddr)) begin
         next_rdData = {7'h00, tbl[regAddr]};
      end else if (bankSel) begin
         case (regAddr)
            tgs_pkg::TGS_OFS_FIRST: next_rdData = {8'h00, firstIdx};
            tgs_pkg::TGS_OFS_LAST:  next_rdData = {8'h00, lastIdx};
            tgs_pkg::TGS_OFS_INIT:  next_rdData = {8'h00, initReg};
            tgs_pkg::TGS_OFS_DWELL: next_rdData = {8'h00, dwellReg};
            tgs_pkg::TGS_OFS_MODE:  next_rdData = {10'h000, modeReg};
            tgs_pkg::TGS_OFS_WHOLE: next_rdData = {10'h000, wholeReg};
            tgs_pkg::TGS_OFS_RATE:  next_rdData = {8'h00, rateReg};
            default:                next_rdData = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdData <= 16'h0000;
      end else begin
         regRdData <= next_rdData;
      end
   end

   // step engine: uniform mode is a walk of identical upward entries
   assign entry   = inTable(idx) ? tbl[idx] : 9'h000;
   assign unitLen = linearSel ? ((rateReg == 8'h00) ? 8'h01 : rateReg)
                              : ((entry[7:0] == 8'h00) ? 8'h01 : entry[7:0]);
   assign goDown  = ~linearSel & entry[tgs_pkg::TGS_BIT_DECR];
   assign delta   = fineSel ? tgs_pkg::TGS_FINE_DELTA : tgs_pkg::TGS_COARSE_DLT;
   assign stepUp  = {1'b0, gainCode} + {6'h00, delta};
   assign outOfRange = goDown ? (gainCode < {5'h00, delta})
                              : (stepUp > {1'b0, tgs_pkg::TGS_GAIN_MAX});
   assign next_gain = goDown ? (gainCode - {5'h00, delta}) : stepUp[8:0];
   assign lastSub = (subIdx == 3'h7);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state    <= tgs_pkg::TGS_IDLE;
         gainCode <= 9'h000;
         idx      <= 8'h00;
         remain   <= 8'h00;
         subCnt   <= 8'h00;
         subIdx   <= 3'h0;
         dwellCnt <= 14'h0000;
      end else if (tick) begin
         case (state)
            tgs_pkg::TGS_IDLE: begin
               if (fixedSel) begin
                  gainCode <= fixedCode;
               end else if (startSync || freeRun) begin
                  gainCode <= initCode;
                  idx      <= firstIdx;
                  remain   <= (lastIdx > firstIdx) ? lastIdx - firstIdx : 8'h00;
                  subCnt   <= 8'h00;
                  subIdx   <= 3'h0;
                  state    <= tgs_pkg::TGS_RAMP;
               end
            end
            tgs_pkg::TGS_RAMP: begin
               if (fixedSel) begin
                  state <= tgs_pkg::TGS_IDLE;
               end else if (subCnt + 8'h01 < unitLen) begin
                  subCnt <= subCnt + 8'h01;
               end else begin
                  subCnt <= 8'h00;
                  subIdx <= subIdx + 3'h1;
                  // final sub-step of the last entry is never applied
                  if (lastSub && remain == 8'h00) begin
                     state    <= tgs_pkg::TGS_DWELL;
                     dwellCnt <= 14'(dwellReg * DWELL_UNIT);
                  end else if (fineSel || lastSub) begin
                     if (outOfRange) begin
                        state    <= tgs_pkg::TGS_DWELL;
                        dwellCnt <= 14'(dwellReg * DWELL_UNIT);
                     end else begin
                        gainCode <= next_gain;
                     end
                  end
                  if (lastSub) begin
                     remain <= remain - 8'h01;
                     idx    <= idx + 8'h01;
                  end
               end
            end
            tgs_pkg::TGS_DWELL: begin
               if (dwellCnt == 14'h0000) begin
                  state <= tgs_pkg::TGS_RETURN;
               end else begin
                  dwellCnt <= dwellCnt - 14'h0001;
               end
            end
            tgs_pkg::TGS_RETURN: begin
               if (gainCode == initCode) begin
                  state <= tgs_pkg::TGS_IDLE;
               end else if (gainCode > initCode + 9'h008) begin
                  gainCode <= gainCode - 9'h008;
               end else if (gainCode + 9'h008 < initCode) begin
                  gainCode <= gainCode + 9'h008;
               end else begin
                  gainCode <= initCode;
               end
            end
            default: state <= tgs_pkg::TGS_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_tick_alternates: assert property (tick |=> !tick ##1 tick)
      else $error("sample tick not every second clock");
   a_gain_on_tick: assert property ($changed(gainCode) |-> $past(tick))
      else $error("gain changed off the sampling instant");
   a_gain_in_range: assert property (gainCode <= tgs_pkg::TGS_GAIN_MAX)
      else $error("gain code left its range");
   a_fixed_gain_value: assert property (
      tick && fixedSel && state == tgs_pkg::TGS_IDLE |=> gainCode == $past(fixedCode))
      else $error("fixed gain not applied");
   a_whole_clamp: assert property (
      tick && fixedSel && state == tgs_pkg::TGS_IDLE && wholeReg > 6'h24
      |=> gainCode[8:3] == 6'h24)
      else $error("whole gain not clamped");
   a_start_loads_init: assert property (
      tick && state == tgs_pkg::TGS_IDLE && !fixedSel && startSync
      |=> state == tgs_pkg::TGS_RAMP && gainCode == $past(initCode))
      else $error("start did not load initial gain");
   a_idle_waits: assert property (
      tick && state == tgs_pkg::TGS_IDLE && !startSync && !freeRun
      |=> state == tgs_pkg::TGS_IDLE)
      else $error("engine left idle without trigger");
   a_dwell_ends: assert property (
      tick && state == tgs_pkg::TGS_DWELL && dwellCnt == 14'h0000
      |=> state == tgs_pkg::TGS_RETURN)
      else $error("dwell did not end on time");
   a_return_step: assert property (
      tick && state == tgs_pkg::TGS_RETURN && gainCode > initCode + 9'h008
      |=> gainCode == $past(gainCode) - 9'h008)
      else $error("return step is not 1 dB");
   a_free_restart: assert property (
      tick && state == tgs_pkg::TGS_RETURN && gainCode == initCode && freeRun && !fixedSel
      |=> ##2 state == tgs_pkg::TGS_RAMP)
      else $error("free run did not restart");

   c_table_dwell: cover property (state == tgs_pkg::TGS_RAMP && !linearSel
                                  ##1 state == tgs_pkg::TGS_DWELL);
   c_uniform_run: cover property (state == tgs_pkg::TGS_RAMP && linearSel && fineSel);
   c_fixed_mode:  cover property (fixedSel && gainCode == fixedCode);
   c_return_idle: cover property (state == tgs_pkg::TGS_RETURN ##1 state == tgs_pkg::TGS_IDLE);
   c_range_stop:  cover property (tick && state == tgs_pkg::TGS_RAMP && outOfRange);

   // dwell ticks seen so far; a count, not a copy of the down-counter,
   // so a wrong load or a skipped decrement shows up as a mismatch
   logic [14:0]           holdTicks;
   logic [13:0]           holdLoad;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         holdTicks <= 15'h0000;
      end else if (state != tgs_pkg::TGS_DWELL) begin
         holdTicks <= 15'h0000;
      end else if (tick) begin
         holdTicks <= holdTicks + 15'h0001;
      end
   end

   // hold length is taken when dwell is entered
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         holdLoad <= 14'h0000;
      end else if (state != tgs_pkg::TGS_DWELL) begin
         holdLoad <= 14'(dwellReg * tgs_pkg::TGS_DWELL_UNIT);
      end
   end

   a_dwell_count: assert property (
      tick && state == tgs_pkg::TGS_DWELL && DWELL_UNIT == tgs_pkg::TGS_DWELL_UNIT
      |-> 15'(dwellCnt) + holdTicks == 15'(holdLoad))
      else $error("dwell length not 33 per count");
   a_dwell_holds: assert property (state == tgs_pkg::TGS_DWELL |=> $stable(gainCode))
      else $error("gain moved during dwell");
   a_coarse_hold: assert property (
      tick && state == tgs_pkg::TGS_RAMP && !fineSel && !lastSub |=> $stable(gainCode))
      else $error("coarse gain moved inside an entry");
   a_coarse_step: assert property (
      tick && state == tgs_pkg::TGS_RAMP && !fineSel && !fixedSel && lastSub
      && subCnt + 8'h01 >= unitLen && remain != 8'h00 && !outOfRange
      |=> gainCode == ($past(goDown) ? $past(gainCode) - 9'h008 : $past(gainCode) + 9'h008))
      else $error("coarse step is not 1 dB");
   a_fine_step: assert property (
      tick && state == tgs_pkg::TGS_RAMP && fineSel && !fixedSel
      && subCnt + 8'h01 >= unitLen && !(lastSub && remain == 8'h00) && !outOfRange
      |=> gainCode == ($past(goDown) ? $past(gainCode) - 9'h001 : $past(gainCode) + 9'h001))
      else $error("fine step is not one eighth");
   a_uniform_up: assert property (
      tick && state == tgs_pkg::TGS_RAMP && linearSel |=> gainCode >= $past(gainCode))
      else $error("uniform ramp went down");
   a_range_stop: assert property (
      tick && state == tgs_pkg::TGS_RAMP && !fixedSel && subCnt + 8'h01 >= unitLen
      && (fineSel || lastSub) && !(lastSub && remain == 8'h00) && outOfRange
      |=> state == tgs_pkg::TGS_DWELL && $stable(gainCode))
      else $error("range overflow did not end ramp");
   a_fixed_idle: assert property (
      tick && fixedSel && (state == tgs_pkg::TGS_IDLE || state == tgs_pkg::TGS_RAMP)
      |=> state == tgs_pkg::TGS_IDLE)
      else $error("engine ran in fixed mode");
   a_free_start: assert property (
      tick && state == tgs_pkg::TGS_IDLE && freeRun && !fixedSel
      |=> state == tgs_pkg::TGS_RAMP)
      else $error("free run did not start");
   a_table_write: assert property (
      regWrEn && bankSel && regAddr == tgs_pkg::TGS_OFS_TBL_LO
      |=> tbl[1] == $past(regWrData[8:0]))
      else $error("table entry not written");
   a_bank_gate: assert property (
      regWrEn && !bankSel && regAddr == tgs_pkg::TGS_OFS_INIT |=> $stable(initReg))
      else $error("write landed with bank off");
   a_last_readback: assert property (
      bankSel && regAddr == tgs_pkg::TGS_OFS_LAST
      |=> regRdData == {8'h00, $past(lastIdx)})
      else $error("last pointer readback wrong");
endmodule : tgs_time_gain_sequencer

// File: bench/tgs_ctl_model.sv
module tgs_ctl_model (
   input  wire logic        clk,
   input  wire logic [15:0] regRdData,
   output logic             regWrEn,
   output logic      [7:0]  regAddr,
   output logic      [15:0] regWrData,
   output logic             startPin
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      regWrEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 16'h0000;
      startPin = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn <= 1'b0;
      // released data bus must not keep the last word
      regWrData <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      @(posedge clk);
      #1 d = regRdData;
   endtask : rd
   // two clk high covers one full sampling period
   task automatic pulse();
      @(posedge clk);
      startPin <= 1'b1;
      repeat (2) @(posedge clk);
      startPin <= 1'b0;
   endtask : pulse
endmodule : tgs_ctl_model

// File: bench/test_time_gain_sequencer.sv
module test_time_gain_sequencer;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk;
   logic        rst_n;
   logic        regWrEn;
   logic [7:0]  regAddr;
   logic [15:0] regWrData;
   logic [15:0] regRdData;
   logic        startPin;
   logic [8:0]  gainCode;
   logic        engineBusy;
   logic [15:0] rv;
   logic [8:0]  prevGain;
   logic        chgPrev;
   int          error_cnt;
   int          n_checks;
   int          n;

   tgs_time_gain_sequencer #(.DWELL_UNIT(2)) u_dut (.clk(clk), .rst_n(rst_n),
      .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .startPin(startPin), .gainCode(gainCode),
      .engineBusy(engineBusy));
   tgs_ctl_model u_ctl (.clk(clk), .regRdData(regRdData), .regWrEn(regWrEn),
      .regAddr(regAddr), .regWrData(regWrData), .startPin(startPin));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // n counts clk edges until the condition holds
   task automatic waitFor(input bit onGain, input logic [8:0] v, input int lim);
      n = 0;
      while ((onGain ? gainCode : {8'h00, engineBusy}) !== v) begin
         @(posedge clk);
         #1 n++;
         if (n > lim) begin
            chk("wait bound", 16'(lim), 16'(n));
            results();
         end
      end
   endtask : waitFor
   // gain may move on sampling edges only, never two clk in a row
   always @(posedge clk) begin
      #1;
      if (rst_n === 1'b1 && chgPrev && gainCode !== prevGain) chk("gain spacing", 0, 1);
      chgPrev = (gainCode !== prevGain);
      prevGain = gainCode;
   end

   task automatic tRegs();
      u_ctl.wr(8'h97, 16'h0086);
      u_ctl.rd(8'h97, rv);
      chk("bank0 write", 16'h0000, rv);
      u_ctl.wr(8'h00, 16'h0004);
      u_ctl.wr(8'h97, 16'h0086);
      u_ctl.rd(8'h97, rv);
      chk("init reg", 16'h0086, rv);
      u_ctl.wr(8'h01, 16'hffff);
      u_ctl.rd(8'h01, rv);
      chk("table width", 16'h01ff, rv);
      u_ctl.rd(8'hc0, rv);
      chk("unmapped", 16'h0000, rv);
   endtask : tRegs
   task automatic tFixed();
      u_ctl.wr(8'h9a, 16'h003f);
      u_ctl.wr(8'h99, 16'h000d);
      repeat (4) @(posedge clk);
      #1 chk("fixed clamp", 16'h0125, 16'(gainCode));
      u_ctl.wr(8'h9a, 16'h0000);
      u_ctl.wr(8'h99, 16'h0008);
      repeat (4) @(posedge clk);
      #1 chk("fixed min", 16'h0000, 16'(gainCode));
      u_ctl.wr(8'h99, 16'h0000);
   endtask : tFixed
   task automatic setUni(input logic [15:0] ini, input logic [15:0] last,
                         input logic [15:0] rate);
      u_ctl.wr(8'h95, 16'h0000);
      u_ctl.wr(8'h96, last);
      u_ctl.wr(8'h97, ini);
      u_ctl.wr(8'h98, 16'h0000);
      u_ctl.wr(8'h9b, rate);
      u_ctl.wr(8'h99, 16'h0010);
   endtask : setUni
   task automatic tUniFine();
      setUni(16'h0082, 16'h0000, 16'h0001);
      u_ctl.pulse();
      waitFor(0, 9'h001, 20);
      chk("start gain", 16'h0010, 16'(gainCode));
      waitFor(1, 9'h017, 40);
      chk("fine span clk", 16'd14, 16'(n));
      waitFor(0, 9'h000, 60);
      chk("returned", 16'h0010, 16'(gainCode));
      repeat (30) @(posedge clk);
      #1 chk("stays idle", 16'h0000, 16'(engineBusy));
   endtask : tUniFine
   task automatic tUniCoarse();
      setUni(16'h0002, 16'h0002, 16'h0002);
      u_ctl.pulse();
      waitFor(0, 9'h001, 20);
      repeat (16) @(posedge clk);
      #1 chk("coarse holds", 16'h0010, 16'(gainCode));
      waitFor(1, 9'h018, 40);
      chk("coarse step clk", 16'd16, 16'(n));
      waitFor(1, 9'h020, 80);
      waitFor(0, 9'h000, 100);
   endtask : tUniCoarse
   task automatic tTable();
      u_ctl.wr(8'h01, 16'h0000);
      u_ctl.wr(8'h02, 16'h0000);
      u_ctl.wr(8'h03, 16'h0100);
      u_ctl.wr(8'h04, 16'h0000);
      u_ctl.wr(8'h95, 16'h0001);
      u_ctl.wr(8'h96, 16'h0004);
      u_ctl.wr(8'h97, 16'h000a);
      u_ctl.wr(8'h98, 16'h0001);
      u_ctl.wr(8'h99, 16'h0000);
      u_ctl.pulse();
      waitFor(0, 9'h001, 20);
      repeat (40) @(posedge clk);
      #1 chk("table peak", 16'h0060, 16'(gainCode));
      repeat (16) @(posedge clk);
      #1 chk("table final", 16'h0058, 16'(gainCode));
      waitFor(0, 9'h000, 100);
      chk("table return", 16'h0050, 16'(gainCode));
   endtask : tTable
   task automatic tFree();
      setUni(16'h0082, 16'h0000, 16'h0001);
      u_ctl.wr(8'h99, 16'h0030);
      waitFor(0, 9'h001, 20);
      waitFor(0, 9'h000, 60);
      waitFor(0, 9'h001, 6);
      u_ctl.wr(8'h99, 16'h0010);
      waitFor(0, 9'h000, 60);
      repeat (30) @(posedge clk);
      #1 chk("free run stop", 16'h0000, 16'(engineBusy));
   endtask : tFree

   initial begin
      error_cnt = 0;
      n_checks = 0;
      chgPrev = 1'b0;
      prevGain = 9'h000;
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 chk("reset gain", 16'h0000, 16'(gainCode));
      chk("reset busy", 16'h0000, 16'(engineBusy));
      tRegs();
      tFixed();
      tUniFine();
      tUniCoarse();
      tTable();
      tFree();
      results();
   end
endmodule : test_time_gain_sequencer
